// ---- servo_cfg_pkg.sv ----
// constants for the servo detector and routing configuration bank
// assumes a 100 MHz clk standing in for the servo master clock timing
package servo_cfg_pkg;

  // ****************************************
  // bus widths
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int LEVEL_W = 8;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_DETECT = 8'h3B;
  localparam logic [7:0] OFS_SETUP = 8'h3C;
  localparam logic [7:0] OFS_ROUTE = 8'h3D;
  localparam logic [7:0] OFS_CORR = 8'h40;
  localparam logic [7:0] OFS_STATUS = 8'h41;

  // ****************************************
  // reset values and writable bit masks
  // ****************************************
  localparam logic [15:0] RST_DETECT = 16'hE050;
  localparam logic [15:0] RST_SETUP = 16'h0080;
  localparam logic [15:0] RST_ROUTE = 16'h0000;
  localparam logic [2:0] RST_CORR = 3'h0;
  localparam logic [15:0] MASK_DETECT = 16'hFFF8;
  localparam logic [15:0] MASK_SETUP = 16'hFEF0;
  localparam logic [15:0] MASK_ROUTE = 16'hF700;

  // ****************************************
  // field positions (lsb of each field)
  // ****************************************
  localparam int BIT_BTF = 8;
  localparam int BIT_HOLD2 = 6;
  localparam int BIT_HOLD1 = 4;
  localparam int BIT_INIT = 3;
  localparam int BIT_ZC_SEL = 14;
  localparam int BIT_ZC_SRC = 13;
  localparam int BIT_FILT_SRC = 12;
  localparam int BIT_CPIN = 10;
  localparam int BIT_MIRROR = 9;
  localparam int BIT_BTS = 6;
  localparam int BIT_MRC = 4;
  localparam int BIT_SLED_SEL = 15;
  localparam int BIT_SLED_SWAP = 14;
  localparam int BIT_HOLD_SEL = 13;
  localparam int BIT_HOLD_SWAP = 12;
  localparam int BIT_TLD = 8;

  // ****************************************
  // timing
  // ****************************************
  localparam real CLK_MHZ = 100.0;
  localparam real STEP_NS = 708.0;
  localparam real SAMPLE_KHZ = 700.0;
  localparam real WIDTH0_US = 5.669;
  localparam real WIDTH1_US = 11.338;
  localparam real WIDTH2_US = 22.675;
  localparam real WIDTH3_US = 45.351;
  localparam int STEP_CYCLES = int'($floor(STEP_NS * CLK_MHZ / 1000.0));
  localparam int SAMPLE_CYCLES = int'($floor(CLK_MHZ * 1000.0 / SAMPLE_KHZ));
  localparam int WIDTH0_CYCLES = int'($ceil(WIDTH0_US * CLK_MHZ));
  localparam int WIDTH1_CYCLES = int'($ceil(WIDTH1_US * CLK_MHZ));
  localparam int WIDTH2_CYCLES = int'($ceil(WIDTH2_US * CLK_MHZ));
  localparam int WIDTH3_CYCLES = int'($ceil(WIDTH3_US * CLK_MHZ));
  localparam int HPF_SHIFT = 7;
  localparam logic [5:0] HOLD1_MASK = 6'h07;
  localparam logic [5:0] HOLD2_MASK = 6'h3F;
  localparam logic [3:0] DOUBLE_STEP = 4'h8;

endpackage

// ---- servo_detect_signal_config.sv ----
// servo detector setup, zero-cross selection and filter input routing
// assumes a synchronous host port and error levels synchronous to clk
//
// Functional notes
// - hold-2 speed code picks 22.05, 44.1, 88.2 or 176.4 kHz counter rate.
// - hold-1 speed code picks 176.4, 352.8, 705.6 or 1411.2 kHz counter rate.
// - init bit resets land-groove detector, high-pass average and zero-cross delay state.
// - count zero-cross select: 1x sampled, 00 high-passed, 01 delayed.
// - sampled zero-cross samples the selected zero-cross source level at 700 kHz.
// - delayed zero-cross is sampled zero-cross delayed by a selectable amount.
// - high-passed zero-cross taken after a 1 kHz high-pass filter.
// - zero-cross source: 0 tracking error, 1 middle error.
// - tracking filter input: 0 tracking error, 1 middle error.
// - count pin: 1x sampled, 01 high-passed, 00 normal count pulse.
// - mirror override puts sampled zero-cross on land-groove pin.
// - bottom-hold count-up gives 1, 2, 4, 8 steps per 708 ns cycle.
// - bottom-hold speed field counts only while double-speed bit is 0.
// - land-groove high only after comparator true for selected width.
// - sled filter input select picks stage-2 output over sled register.
// - sled coefficient swap acts only during gain-up2.
// - hold filter input select picks stage-2 output over sled register.
// - hold coefficient swap acts only during gain-up2.
// - corrections: enable 0 off; sled-disable 1 keeps tracking only.
// - double-speed bit puts bottom hold into double count-up mode.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module servo_detect_signal_config #(
  parameter int MIN_WIDTH0 = servo_cfg_pkg::WIDTH0_CYCLES,
  parameter int MIN_WIDTH1 = servo_cfg_pkg::WIDTH1_CYCLES,
  parameter int MIN_WIDTH2 = servo_cfg_pkg::WIDTH2_CYCLES,
  parameter int MIN_WIDTH3 = servo_cfg_pkg::WIDTH3_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [servo_cfg_pkg::ADDR_W-1:0] addr,
  input wire logic [servo_cfg_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [servo_cfg_pkg::DATA_W-1:0] rdata,
  input wire logic [servo_cfg_pkg::LEVEL_W-1:0] te_level,
  input wire logic [servo_cfg_pkg::LEVEL_W-1:0] ce_level,
  input wire logic zc_delay_sel,
  input wire logic gain_up2,
  input wire logic level_above,
  input wire logic count_pulse_in,
  output logic hold1_tick,
  output logic hold2_tick,
  output logic bottom_step,
  output logic [3:0] bottom_step_size,
  output logic detector_init,
  output logic track_zero_cross,
  output logic land_groove_detect,
  output logic count_pin,
  output logic mirror_pin,
  output logic [servo_cfg_pkg::LEVEL_W-1:0] trk_filter_in,
  output logic sled_input_select,
  output logic sled_coeff_swap,
  output logic hold_input_select,
  output logic hold_coeff_swap,
  output logic [2:0] trk_corr_on,
  output logic [2:0] sld_corr_on
);
  import servo_cfg_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] detect;
    logic [15:0] setup;
    logic [15:0] route;
    logic [2:0] corr;
    logic [15:0] rdata;
    logic [6:0] step_cnt;
    logic [5:0] base_div;
    logic hold1_tick;
    logic hold2_tick;
    logic bottom_step;
    logic [3:0] bottom_step_size;
    logic [7:0] zc_cnt;
    logic sampled_zero_cross;
    logic [1:0] dly;
    logic delayed_zero_cross;
    logic signed [16:0] hp_avg;
    logic hpzc;
    logic [12:0] lg_cnt;
    logic lg_detect;
    logic det_init;
    logic track_zc;
    logic count_pin;
    logic mirror_pin;
    logic [7:0] trk_in;
    logic sled_sel;
    logic sled_swap;
    logic hold_sel;
    logic hold_swap;
    logic [2:0] trk_corr;
    logic [2:0] sld_corr;
  } state_type;

  state_type s;
  state_type next_s;

  logic base_tick;
  logic zc_tick;
  logic [1:0] hold2_code;
  logic [1:0] hold1_code;
  logic [1:0] zc_sel;
  logic [1:0] cpin_sel;
  logic [1:0] mrc_code;
  logic [1:0] bts_code;
  logic [7:0] zc_level;
  logic signed [16:0] hp_diff;
  logic [12:0] lg_limit;

  // ****************************************
  // field decode
  // ****************************************
  assign hold2_code = s.detect[BIT_HOLD2 +: 2];
  assign hold1_code = s.detect[BIT_HOLD1 +: 2];
  assign zc_sel = s.setup[BIT_ZC_SEL +: 2];
  assign cpin_sel = s.setup[BIT_CPIN +: 2];
  assign mrc_code = s.setup[BIT_MRC +: 2];
  assign bts_code = s.setup[BIT_BTS +: 2];
  assign base_tick = (s.step_cnt == 7'(STEP_CYCLES - 1));
  assign zc_tick = (s.zc_cnt == 8'(SAMPLE_CYCLES - 1));
  // zero-cross source mux
  assign zc_level = s.setup[BIT_ZC_SRC] ? ce_level : te_level;
  // high-pass: distance of scaled sample from running average
  assign hp_diff = (17'(signed'(zc_level)) <<< HPF_SHIFT) - s.hp_avg;

  // minimum land-groove width per code
  always_comb begin
    case (mrc_code)
      2'h0: lg_limit = 13'(MIN_WIDTH0);
      2'h1: lg_limit = 13'(MIN_WIDTH1);
      2'h2: lg_limit = 13'(MIN_WIDTH2);
      default: lg_limit = 13'(MIN_WIDTH3);
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.det_init = 1'b0;
    next_s.rdata = 16'h0000;
    // register writes, fixed-zero bits dropped
    if (wr) begin
      case (addr)
        OFS_DETECT: begin
          next_s.detect = wdata & MASK_DETECT;
          next_s.det_init = wdata[BIT_INIT];
        end
        OFS_SETUP: next_s.setup = wdata & MASK_SETUP;
        OFS_ROUTE: next_s.route = wdata & MASK_ROUTE;
        OFS_CORR: next_s.corr = wdata[2:0];
        default: next_s.corr = s.corr;
      endcase
    end
    // register reads, answered next cycle
    if (rd) begin
      case (addr)
        OFS_DETECT: next_s.rdata = s.detect;
        OFS_SETUP: next_s.rdata = s.setup;
        OFS_ROUTE: next_s.rdata = s.route;
        OFS_CORR: next_s.rdata = {13'h0000, s.corr};
        OFS_STATUS: next_s.rdata = {11'h000, s.lg_detect, s.track_zc, s.delayed_zero_cross,
                                    s.hpzc, s.sampled_zero_cross};
        default: next_s.rdata = 16'h0000;
      endcase
    end
    // base step divider, 70 cycles (700 ns at 100 MHz) per tick
    next_s.step_cnt = base_tick ? 7'h00 : s.step_cnt + 7'h01;
    next_s.base_div = base_tick ? s.base_div + 6'h01 : s.base_div;
    // peak-hold count-down enables
    next_s.hold1_tick = base_tick && ((s.base_div & (HOLD1_MASK >> hold1_code)) == 6'h00);
    next_s.hold2_tick = base_tick && ((s.base_div & (HOLD2_MASK >> hold2_code)) == 6'h00);
    // bottom-hold count-up step
    next_s.bottom_step = base_tick;
    if (s.detect[BIT_BTF]) begin
      next_s.bottom_step_size = DOUBLE_STEP;
    end else begin
      next_s.bottom_step_size = 4'h1 << bts_code;
    end
    // sampled and delayed zero-cross
    next_s.zc_cnt = zc_tick ? 8'h00 : s.zc_cnt + 8'h01;
    if (zc_tick) begin
      next_s.sampled_zero_cross = ~zc_level[LEVEL_W-1];
      next_s.dly = {s.dly[0], s.sampled_zero_cross};
      next_s.delayed_zero_cross = zc_delay_sel ? s.dly[1] : s.dly[0];
      next_s.hp_avg = s.hp_avg + (hp_diff >>> HPF_SHIFT);
      next_s.hpzc = ~hp_diff[16];
    end
    // land-groove minimum width qualifier
    if (!level_above) begin
      next_s.lg_cnt = 13'h0000;
      next_s.lg_detect = 1'b0;
    end else if (s.lg_cnt >= lg_limit - 13'h0001) begin
      next_s.lg_detect = 1'b1;
    end else begin
      next_s.lg_cnt = s.lg_cnt + 13'h0001;
    end
    // detector init clears detector state
    if (s.det_init) begin
      next_s.lg_cnt = 13'h0000;
      next_s.lg_detect = 1'b0;
      next_s.hp_avg = 17'h00000;
      next_s.dly = 2'h0;
    end
    // zero-cross for the count logic
    if (zc_sel[1]) begin
      next_s.track_zc = s.sampled_zero_cross;
    end else if (zc_sel[0]) begin
      next_s.track_zc = s.delayed_zero_cross;
    end else begin
      next_s.track_zc = s.hpzc;
    end
    // count pin source
    if (cpin_sel[1]) begin
      next_s.count_pin = s.sampled_zero_cross;
    end else if (cpin_sel[0]) begin
      next_s.count_pin = s.hpzc;
    end else begin
      next_s.count_pin = count_pulse_in;
    end
    // mirror pin source
    next_s.mirror_pin = s.setup[BIT_MIRROR] ? s.sampled_zero_cross : s.lg_detect;
    // tracking filter input
    next_s.trk_in = s.setup[BIT_FILT_SRC] ? ce_level : te_level;
    // sled and hold routing
    next_s.sled_sel = s.route[BIT_SLED_SEL];
    next_s.sled_swap = s.route[BIT_SLED_SWAP] && gain_up2;
    next_s.hold_sel = s.route[BIT_HOLD_SEL];
    next_s.hold_swap = s.route[BIT_HOLD_SWAP] && gain_up2;
    // corrections per filter
    next_s.trk_corr = s.corr;
    next_s.sld_corr = s.corr & ~s.route[BIT_TLD +: 3];
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.detect <= RST_DETECT;
      s.setup <= RST_SETUP;
      s.route <= RST_ROUTE;
      s.corr <= RST_CORR;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state register
  assign rdata = s.rdata;
  assign hold1_tick = s.hold1_tick;
  assign hold2_tick = s.hold2_tick;
  assign bottom_step = s.bottom_step;
  assign bottom_step_size = s.bottom_step_size;
  assign detector_init = s.det_init;
  assign track_zero_cross = s.track_zc;
  assign land_groove_detect = s.lg_detect;
  assign count_pin = s.count_pin;
  assign mirror_pin = s.mirror_pin;
  assign trk_filter_in = s.trk_in;
  assign sled_input_select = s.sled_sel;
  assign sled_coeff_swap = s.sled_swap;
  assign hold_input_select = s.hold_sel;
  assign hold_coeff_swap = s.hold_swap;
  assign trk_corr_on = s.trk_corr;
  assign sld_corr_on = s.sld_corr;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_hold2_rate;
    hold2_tick && hold2_code == 2'h1 |=> !hold2_tick [*8];
  endproperty
  a_hold2_rate: assert property (p_hold2_rate) else $error("hold2 tick too fast");

  property p_hold1_subset;
    hold1_tick |-> bottom_step;
  endproperty
  a_hold1_subset: assert property (p_hold1_subset) else $error("hold1 off base");

  property p_init_clears;
    detector_init |=> !land_groove_detect;
  endproperty
  a_init_clears: assert property (p_init_clears) else $error("init left detect");

  property p_count_sampled_zero_cross;
    zc_sel[1] && cpin_sel == 2'h0 && $stable(zc_sel) |=> track_zero_cross == $past(s.sampled_zero_cross);
  endproperty
  a_count_sampled_zero_cross: assert property (p_count_sampled_zero_cross) else $error("zc select wrong");

  property p_sample_hold;
    !zc_tick |=> $stable(s.sampled_zero_cross);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("sampled_zero_cross off tick");

  property p_cpin_hp;
    cpin_sel == 2'h1 |=> count_pin == $past(s.hpzc);
  endproperty
  a_cpin_hp: assert property (p_cpin_hp) else $error("count pin wrong");

  property p_mirror;
    s.setup[BIT_MIRROR] |=> mirror_pin == $past(s.sampled_zero_cross);
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror override wrong");

  property p_step_size;
    !s.detect[BIT_BTF] && bts_code == 2'h3 |=> bottom_step_size == 4'h8;
  endproperty
  a_step_size: assert property (p_step_size) else $error("step size wrong");

  property p_lg_min;
    $rose(land_groove_detect) |-> $past(level_above, 2) && $past(level_above, 3);
  endproperty
  a_lg_min: assert property (p_lg_min) else $error("detect too early");

  property p_swap;
    sled_coeff_swap |-> $past(gain_up2);
  endproperty
  a_swap: assert property (p_swap) else $error("swap outside gain-up2");

  property p_corr;
    (sld_corr_on & ~trk_corr_on) == 3'h0;
  endproperty
  a_corr: assert property (p_corr) else $error("sled corr without trk");

  property p_hold1_fast;
    base_tick && hold1_code == 2'h3 |=> hold1_tick;
  endproperty
  a_hold1_fast: assert property (p_hold1_fast) else $error("hold1 missed base");

  property p_init_pulse;
    detector_init && !wr |=> !detector_init;
  endproperty
  a_init_pulse: assert property (p_init_pulse) else $error("init not a pulse");

  property p_filter_src;
    s.setup[BIT_FILT_SRC] |=> trk_filter_in == $past(ce_level);
  endproperty
  a_filter_src: assert property (p_filter_src) else $error("filter source wrong");

  property p_double_speed;
    s.detect[BIT_BTF] |=> bottom_step_size == DOUBLE_STEP;
  endproperty
  a_double_speed: assert property (p_double_speed) else $error("double speed size");

  property p_lg_drop;
    !level_above |=> !land_groove_detect;
  endproperty
  a_lg_drop: assert property (p_lg_drop) else $error("detect without level");

  property p_sled_sel;
    sled_input_select == $past(s.route[BIT_SLED_SEL]);
  endproperty
  a_sled_sel: assert property (p_sled_sel) else $error("sled select wrong");

  property p_hold_sel;
    hold_input_select == $past(s.route[BIT_HOLD_SEL]);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("hold select wrong");

  property p_hold_swap;
    hold_coeff_swap |-> $past(gain_up2);
  endproperty
  a_hold_swap: assert property (p_hold_swap) else $error("hold swap outside gain-up2");

  c_lg_detect: cover property ($rose(land_groove_detect));
  c_init: cover property (detector_init);
  c_mirror: cover property (s.setup[BIT_MIRROR] && mirror_pin);
  c_swap: cover property (hold_coeff_swap);

endmodule

`default_nettype wire

// ---- host_model.sv ----
// host side model: writes and reads servo command words on the register port
// assumes rdata stands only in the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [servo_cfg_pkg::ADDR_W-1:0] addr,
  output logic [servo_cfg_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [servo_cfg_pkg::DATA_W-1:0] rdata
);
  import servo_cfg_pkg::*;
  // bus idle at time zero
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one write cycle; released lines show the inverse of the last value
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // one read cycle; data taken at the edge closing the answer cycle
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask
  // sign flip of the input gain when stage-2 routing is chosen
  function automatic logic [7:0] flip_coeff(input logic [7:0] k);
    return k ^ 8'h80;
  endfunction
endmodule
`default_nettype wire

// ---- tb_servo_detect_signal_config.sv ----
// self-checking bench for the servo detector configuration bank
// assumes host_model as bus master and shortened land-groove minimum width parameters
`timescale 1ns/1ps
`default_nettype none
module tb_servo_detect_signal_config;
  import servo_cfg_pkg::*;
  typedef struct packed {
    logic [15:0] setup; logic [15:0] route; logic [2:0] corr; logic bottom_hold_double_speed; logic gain;
    logic [3:0] sw; logic [2:0] tracking_servo; logic [2:0] sled_input_register; logic [3:0] step;
  } row_type;
  row_type rows [6] = '{
    '{16'h8000, 16'h0000, 3'h0, 1'b0, 1'b0, 4'h0, 3'h0, 3'h0, 4'h1},
    '{16'hC040, 16'hC000, 3'h7, 1'b0, 1'b1, 4'hC, 3'h7, 3'h7, 4'h2},
    '{16'hA880, 16'h3500, 3'h7, 1'b0, 1'b1, 4'h3, 3'h7, 3'h2, 4'h4},
    '{16'h92C0, 16'hF700, 3'h5, 1'b0, 1'b0, 4'hA, 3'h5, 3'h0, 4'h8},
    '{16'h8E40, 16'h0200, 3'h3, 1'b1, 1'b1, 4'h0, 3'h3, 3'h1, 4'h8},
    '{16'h0080, 16'h4000, 3'h2, 1'b0, 1'b1, 4'h4, 3'h2, 3'h2, 4'h4}};
  int widths [4] = '{5, 10, 20, 40};
  int miscompares = 0;
  int tests_run = 0;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr, te_level, ce_level;
  logic [15:0] wdata, rdata, v;
  logic wr, rd, zc_delay_sel, gain_up2, level_above, count_pulse_in;
  logic hold1_tick, hold2_tick, bottom_step, detector_init, track_zero_cross;
  logic land_groove_detect, count_pin, mirror_pin, stz, seen;
  logic sled_input_select, sled_coeff_swap, hold_input_select, hold_coeff_swap;
  logic [3:0] bottom_step_size;
  logic [7:0] trk_filter_in;
  logic [2:0] trk_corr_on, sld_corr_on;
  int n;

  host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  servo_detect_signal_config #(.MIN_WIDTH0(5), .MIN_WIDTH1(10), .MIN_WIDTH2(20),
    .MIN_WIDTH3(40)) dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .te_level(te_level), .ce_level(ce_level), .zc_delay_sel(zc_delay_sel),
    .gain_up2(gain_up2), .level_above(level_above), .count_pulse_in(count_pulse_in),
    .hold1_tick(hold1_tick), .hold2_tick(hold2_tick), .bottom_step(bottom_step),
    .bottom_step_size(bottom_step_size), .detector_init(detector_init),
    .track_zero_cross(track_zero_cross), .land_groove_detect(land_groove_detect),
    .count_pin(count_pin), .mirror_pin(mirror_pin), .trk_filter_in(trk_filter_in),
    .sled_input_select(sled_input_select), .sled_coeff_swap(sled_coeff_swap),
    .hold_input_select(hold_input_select), .hold_coeff_swap(hold_coeff_swap),
    .trk_corr_on(trk_corr_on), .sld_corr_on(sld_corr_on));

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  // **************************************
  // helpers
  // **************************************
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  function automatic logic pick(input int w);
    return (w == 0) ? hold1_tick : (w == 1) ? hold2_tick : bottom_step;
  endfunction
  // cycles between two pulses of the chosen tick
  task automatic period(input int w, output int p);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (pick(w) !== 1'b1 && k < 5000);
    p = 0;
    do begin
      @(posedge clk);
      #1;
      p++;
    end while (pick(w) !== 1'b1 && p < 5000);
  endtask
  // cycles from raising the level until the detector goes high
  task automatic lg_rise(output int p);
    level_above <= 1'b1;
    p = 0;
    do begin
      @(posedge clk);
      #1;
      p++;
    end while (land_groove_detect !== 1'b1 && p < 200);
  endtask
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // **************************************
  // main sequence
  // **************************************
  initial begin
    te_level = 8'h12;
    ce_level = 8'hA5;
    zc_delay_sel = 1'b0;
    gain_up2 = 1'b0;
    level_above = 1'b0;
    count_pulse_in = 1'b0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({12'h0, bottom_step_size}, 16'h0004);
    chk({8'h0, host.flip_coeff(8'hE0)}, 16'h0060);
    host.read_reg(OFS_DETECT, v);
    chk(v, 16'hE050);
    host.read_reg(OFS_SETUP, v);
    chk(v, 16'h0080);
    host.read_reg(OFS_ROUTE, v);
    chk(v, 16'h0000);
    // table of static settings
    foreach (rows[i]) begin
      host.write_reg(OFS_SETUP, rows[i].setup);
      host.write_reg(OFS_ROUTE, rows[i].route);
      host.write_reg(OFS_CORR, {13'h0, rows[i].corr});
      host.write_reg(OFS_DETECT, 16'hE050 | {7'h0, rows[i].bottom_hold_double_speed, 8'h0});
      gain_up2 <= rows[i].gain;
      count_pulse_in <= i[0];
      repeat (300) @(posedge clk);
      #1;
      stz = ~(rows[i].setup[13] ? ce_level[7] : te_level[7]);
      chk({12'h0, sled_input_select, sled_coeff_swap, hold_input_select, hold_coeff_swap},
        {12'h0, rows[i].sw});
      chk({10'h0, trk_corr_on, sld_corr_on}, {10'h0, rows[i].tracking_servo, rows[i].sled_input_register});
      chk({12'h0, bottom_step_size}, {12'h0, rows[i].step});
      chk({8'h0, trk_filter_in}, {8'h0, rows[i].setup[12] ? ce_level : te_level});
      chk({15'h0, count_pin}, {15'h0, rows[i].setup[11] ? stz : i[0]});
      chk({15'h0, mirror_pin}, {15'h0, rows[i].setup[9] & stz});
      if (rows[i].setup[15]) begin
        chk({15'h0, track_zero_cross}, {15'h0, stz});
      end
      host.read_reg(OFS_SETUP, v);
      chk(v, rows[i].setup & MASK_SETUP);
      host.read_reg(OFS_ROUTE, v);
      chk(v, rows[i].route & MASK_ROUTE);
    end
    // high-passed and delayed zero-cross across a rising and a falling level step
    host.write_reg(OFS_SETUP, 16'h4400);
    te_level <= 8'h70;
    repeat (3 * SAMPLE_CYCLES) @(posedge clk);
    #1;
    chk({15'h0, count_pin}, 16'h0001);
    @(posedge clk);
    te_level <= 8'h90;
    n = 0;
    do begin
      host.read_reg(OFS_STATUS, v);
      n++;
    end while (v[0] !== 1'b0 && n < 100);
    chk(v, 16'h000C);
    repeat (4 * SAMPLE_CYCLES) @(posedge clk);
    #1;
    chk({14'h0, track_zero_cross, count_pin}, 16'h0000);
    // fixed-zero bits and an unmapped place
    host.write_reg(OFS_SETUP, 16'hFFFF);
    host.write_reg(OFS_ROUTE, 16'hFFFF);
    host.write_reg(8'h7F, 16'h1234);
    host.read_reg(OFS_SETUP, v);
    chk(v, 16'hFEF0);
    host.read_reg(OFS_ROUTE, v);
    chk(v, 16'hF700);
    host.read_reg(8'h7F, v);
    chk(v, 16'h0000);
    // counter rates for every speed code
    for (int c = 0; c < 4; c++) begin
      host.write_reg(OFS_DETECT, 16'hE000 | 16'(c << 6) | 16'(c << 4));
      zc_delay_sel <= c[0];
      period(0, n);
      chk(16'(n), 16'(STEP_CYCLES * (8 >> c)));
      period(1, n);
      chk(16'(n), 16'(STEP_CYCLES * (64 >> c)));
    end
    period(2, n);
    chk(16'(n), 16'(STEP_CYCLES));
    // minimum width per code, after an interrupted first attempt
    for (int c = 0; c < 4; c++) begin
      host.write_reg(OFS_SETUP, 16'h8000 | 16'(c << 4));
      level_above <= 1'b1;
      repeat (3) @(posedge clk);
      level_above <= 1'b0;
      @(posedge clk);
      #1;
      chk({15'h0, land_groove_detect}, 16'h0000);
      lg_rise(n);
      chk({15'h0, n >= widths[c] && n <= widths[c] + 1}, 16'h0001);
      if (c < 3) begin
        level_above <= 1'b0;
        repeat (3) @(posedge clk);
      end
    end
    // init pulse while the detector is high
    host.write_reg(OFS_DETECT, 16'hE058);
    seen = 1'b0;
    repeat (3) begin
      #1;
      seen = seen | (detector_init === 1'b1);
      @(posedge clk);
    end
    #1;
    chk({15'h0, seen}, 16'h0001);
    chk({15'h0, land_groove_detect}, 16'h0000);
    host.read_reg(OFS_DETECT, v);
    chk(v, 16'hE058 & MASK_DETECT);
    level_above <= 1'b0;
    // reset in mid-run brings the presets back
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    host.read_reg(OFS_SETUP, v);
    chk(v, RST_SETUP);
    host.read_reg(OFS_DETECT, v);
    chk(v, RST_DETECT);
    final_report();
  end
endmodule
`default_nettype wire
